// *** design/outport_pkg.sv ***
/*
  package for the bit set/reset output port: register offsets, widths, reset values
  and mode-register field positions.
  assumes a plain byte-addressed register port with 32-bit data.
*/
package outport_pkg;
    localparam int PIN_COUNT = 8;
    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 32;
    // register offsets (byte addresses, one aligned word each)
    localparam logic [7:0] OFS_LATCH_SET = 8'h00;
    localparam logic [7:0] OFS_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OFS_PIN_FUNCTION_CONFIG = 8'h08;
    localparam logic [7:0] OFS_CHAN_A_MODE_FIRST = 8'h0C;
    localparam logic [7:0] OFS_CHAN_B_MODE_FIRST = 8'h10;
    localparam logic [7:0] OFS_CHAN_A_MODE_SECOND = 8'h14;
    localparam logic [7:0] OFS_CHAN_B_MODE_SECOND = 8'h18;
    localparam logic [7:0] OFS_LATCH_STATUS = 8'h1C;
    // reset values
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    // field positions
    localparam int MODE_FIRST_RX_RTS_BIT = 7;
    localparam int MODE_SECOND_TX_RTS_BIT = 5;
    localparam int CHAN_A_PIN = 0;
    localparam int CHAN_B_PIN = 1;
    localparam int FIRST_CONFIG_PIN = 2;
endpackage

// *** design/pin_ctrl_if.sv ***
/*
  interface between the register/latch logic and the pin driver.
  assumes both ends run on the same clock; carries levels only.
*/
`timescale 1ns/1ps
`default_nettype none
interface pin_ctrl_if;
    logic [7:0] latch;
    logic [7:0] auxSel;
    logic [7:0] auxSrc;
    logic [7:0] pinLevel;
    modport ctrl (output latch, output auxSel, output auxSrc, input pinLevel);
    modport drv (input latch, input auxSel, input auxSrc, output pinLevel);
endinterface
`default_nettype wire

// *** design/out_pin_driver.sv ***
/*
  per-pin output selector: each pin drives the inverted latch bit or the inverted
  auxiliary source chosen for it.
  assumes selects and sources are synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module out_pin_driver (
    input wire logic clk,
    input wire logic nrst,
    pin_ctrl_if.drv pins
);
    import outport_pkg::*;

    logic [PIN_COUNT-1:0] level_r;
    logic [PIN_COUNT-1:0] level_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    genvar i;
    generate
        for (i = 0; i < PIN_COUNT; i++) begin : g_pin
            always_comb begin
                if (pins.auxSel[i]) begin
                    level_nxt[i] = ~pins.auxSrc[i]; // RULE_05
                end else begin
                    level_nxt[i] = ~pins.latch[i]; // RULE_04
                end
            end
        end
    endgenerate

    // registered so the pins never glitch while selects change
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            level_r <= ~RST_LATCH;
        end else begin
            level_r <= level_nxt;
        end
    end

    assign pins.pinLevel = level_r;
endmodule
`default_nettype wire

// *** design/output_port_bit_set_reset.sv ***
/*
  eight-bit general purpose output port with separate bit-set and bit-clear
  addresses, inverted pins and per-pin auxiliary functions.
  assumes a register port whose strobes last one cycle and never overlap;
  auxiliary sources (channel handshakes, interrupt requests, timer) come from outside.
  reads of the set and clear offsets return zero.
*/
// Notes on behaviour
// (RULE_01) eight latch bits, each individually changeable
// (RULE_02) set-address write forces selected bits high
// (RULE_03) clear-address write forces selected bits low
// (RULE_04) pins drive complement of latch bits
// (RULE_05) each pin may carry auxiliary channel function
// (RULE_06) pins two to seven carry interrupt outputs; the config register selects pins 2 to 7
// (RULE_07) reset clears latch, pins idle high
`timescale 1ns/1ps
`default_nettype none
module output_port_bit_set_reset (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [outport_pkg::ADDR_WIDTH-1:0] regAddr,
    input wire logic [outport_pkg::DATA_WIDTH-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [outport_pkg::DATA_WIDTH-1:0] regRdata,
    input wire logic [outport_pkg::PIN_COUNT-1:0] auxSource,
    output logic [outport_pkg::PIN_COUNT-1:0] outPins
);
    import outport_pkg::*;

    logic [7:0] latch_r;
    logic [7:0] latch_nxt;
    logic [7:0] pinCfg_r;
    logic [7:0] pinCfg_nxt;
    logic [7:0] aModeFirst_r;
    logic [7:0] aModeFirst_nxt;
    logic [7:0] bModeFirst_r;
    logic [7:0] bModeFirst_nxt;
    logic [7:0] aModeSecond_r;
    logic [7:0] aModeSecond_nxt;
    logic [7:0] bModeSecond_r;
    logic [7:0] bModeSecond_nxt;
    logic [DATA_WIDTH-1:0] rdata_r;
    logic [DATA_WIDTH-1:0] rdata_nxt;
    logic [7:0] wByte;
    logic setHit;
    logic clearHit;
    // copies for the function select; the pins use only the handshake bits of the modes
    logic [7:0] auxSel;
    logic [7:0] modeFirst [2];
    logic [7:0] modeSecond [2];

    // latch, selects and sources travel to the pin driver together
    pin_ctrl_if pinBus ();

    ////////////////////////////////////////////////////////////////////////////////
    // register writes
    assign wByte = regWdata[7:0];
    // set and clear live at different offsets, so one write never asks for both
    assign setHit = regWrite && (regAddr == OFS_LATCH_SET);
    assign clearHit = regWrite && (regAddr == OFS_LATCH_CLEAR);

    // each latch bit looks only at its own data bit; zeros leave neighbours alone
    genvar b;
    generate
        for (b = 0; b < PIN_COUNT; b++) begin : g_latch
            always_comb begin
                if (setHit && wByte[b]) begin
                    latch_nxt[b] = 1'b1; // RULE_01 RULE_02
                end else if (clearHit && wByte[b]) begin
                    latch_nxt[b] = 1'b0; // RULE_01 RULE_03
                end else begin
                    latch_nxt[b] = latch_r[b];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            latch_r <= RST_LATCH; // RULE_07
        end else begin
            latch_r <= latch_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin function config
    always_comb begin
        pinCfg_nxt = pinCfg_r;
        if (regWrite && (regAddr == OFS_PIN_FUNCTION_CONFIG)) begin
            pinCfg_nxt = wByte; // RULE_05
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pinCfg_r <= RST_CONFIG;
        end else begin
            pinCfg_r <= pinCfg_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // channel mode registers; only the handshake bits reach the pins
    always_comb begin
        aModeFirst_nxt = aModeFirst_r;
        bModeFirst_nxt = bModeFirst_r;
        aModeSecond_nxt = aModeSecond_r;
        bModeSecond_nxt = bModeSecond_r;
        if (regWrite) begin
            case (regAddr)
                OFS_CHAN_A_MODE_FIRST: begin
                    aModeFirst_nxt = wByte;
                end
                OFS_CHAN_B_MODE_FIRST: begin
                    bModeFirst_nxt = wByte;
                end
                OFS_CHAN_A_MODE_SECOND: begin
                    aModeSecond_nxt = wByte;
                end
                OFS_CHAN_B_MODE_SECOND: begin
                    bModeSecond_nxt = wByte;
                end
                // latch, config, unmapped and read-only offsets leave the modes alone
                default: begin
                    aModeFirst_nxt = aModeFirst_r;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aModeFirst_r <= RST_MODE;
            bModeFirst_r <= RST_MODE;
            aModeSecond_r <= RST_MODE;
            bModeSecond_r <= RST_MODE;
        end else begin
            aModeFirst_r <= aModeFirst_nxt;
            bModeFirst_r <= bModeFirst_nxt;
            aModeSecond_r <= aModeSecond_nxt;
            bModeSecond_r <= bModeSecond_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register reads; the set/clear offsets are write-only and read as zero
    always_comb begin
        rdata_nxt = '0;
        if (regRead) begin
            case (regAddr)
                OFS_PIN_FUNCTION_CONFIG: begin
                    rdata_nxt[7:0] = pinCfg_r;
                end
                OFS_CHAN_A_MODE_FIRST: begin
                    rdata_nxt[7:0] = aModeFirst_r;
                end
                OFS_CHAN_B_MODE_FIRST: begin
                    rdata_nxt[7:0] = bModeFirst_r;
                end
                OFS_CHAN_A_MODE_SECOND: begin
                    rdata_nxt[7:0] = aModeSecond_r;
                end
                OFS_CHAN_B_MODE_SECOND: begin
                    rdata_nxt[7:0] = bModeSecond_r;
                end
                OFS_LATCH_STATUS: begin
                    rdata_nxt[7:0] = latch_r;
                end
                default: begin
                    rdata_nxt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // read data lasts one cycle, then drops back to zero so it never looks fresh
    assign regRdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////////////
    // function select: pins 0 and 1 follow the channel modes, the rest the config
    assign modeFirst[0] = aModeFirst_r;
    assign modeFirst[1] = bModeFirst_r;
    assign modeSecond[0] = aModeSecond_r;
    assign modeSecond[1] = bModeSecond_r;

    // either handshake mode hands the pin over to its channel
    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_chan
            assign auxSel[CHAN_A_PIN + c] = modeFirst[c][MODE_FIRST_RX_RTS_BIT]
                | modeSecond[c][MODE_SECOND_TX_RTS_BIT]; // RULE_05
        end
    endgenerate

    // pins 2..7 may carry transmitter, receiver and timer interrupts
    assign auxSel[PIN_COUNT-1:FIRST_CONFIG_PIN] =
        pinCfg_r[PIN_COUNT-1:FIRST_CONFIG_PIN]; // RULE_05 RULE_06

    assign pinBus.latch = latch_r;
    assign pinBus.auxSel = auxSel;
    // sources are inverted too, so an asserted request pulls its pin low
    assign pinBus.auxSrc = auxSource;

    // the driver registers the pins, so they trail the latch by one cycle
    out_pin_driver driver (
        .clk(clk),
        .nrst(nrst),
        .pins(pinBus.drv)
    );

    assign outPins = pinBus.pinLevel; // RULE_04
endmodule
`default_nettype wire

// *** tb/outport_props.sv ***
/* assertions on the output port; sees only the top ports, bound below */
`timescale 1ns/1ps
`default_nettype none
module outport_props (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regRdata,
    input wire logic [7:0] auxSource,
    input wire logic [7:0] outPins
);
    logic [7:0] rg_r [8];
    wire logic [7:0] sel = {rg_r[2][7:2], rg_r[4][7] | rg_r[6][5], rg_r[3][7] | rg_r[5][5]};
    wire logic [7:0] want = (~rg_r[7] & ~sel) | (~auxSource & sel);
    // shadow of latch (slot 7) and config/mode registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rg_r <= '{default: '0};
        end else if (regWrite && regAddr[1:0] == 2'h0) begin
            case (regAddr[7:2])
                6'h00: rg_r[7] <= rg_r[7] | regWdata[7:0];
                6'h01: rg_r[7] <= rg_r[7] & ~regWdata[7:0];
                6'h02, 6'h03, 6'h04, 6'h05, 6'h06: rg_r[regAddr[4:2]] <= regWdata[7:0];
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_pins; outPins == $past(want); endproperty
    a_pins: assert property (p_pins) else $error("pin level wrong");
    property p_rst; $rose(nrst) |-> outPins == 8'hFF; endproperty
    a_rst: assert property (p_rst) else $error("pins not high after reset");
    property p_idle; !$past(regRead) |-> regRdata == '0; endproperty
    a_idle: assert property (p_idle) else $error("read data not zero");
    property p_stat; regRead && regAddr == 8'h1C |=> regRdata[7:0] == $past(rg_r[7]); endproperty
    a_stat: assert property (p_stat) else $error("latch read wrong");
    property p_set;
        regWrite && regAddr == 8'h00 ##1 regRead && regAddr == 8'h1C
        |=> (regRdata[7:0] & $past(regWdata[7:0], 2)) == $past(regWdata[7:0], 2);
    endproperty
    a_set: assert property (p_set) else $error("set bits missing");
    property p_clr;
        regWrite && regAddr == 8'h04 ##1 regRead && regAddr == 8'h1C
        |=> (regRdata[7:0] & $past(regWdata[7:0], 2)) == 8'h00;
    endproperty
    a_clr: assert property (p_clr) else $error("cleared bits still set");
    property p_cfg;
        regWrite && regAddr == 8'h08 ##1 regRead && regAddr == 8'h08
        |=> regRdata[7:0] == $past(regWdata[7:0], 2);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config read back wrong");
    property p_wo; regRead && (regAddr < 8'h08 || regAddr > 8'h1C) |=> regRdata == '0; endproperty
    a_wo: assert property (p_wo) else $error("write-only read not zero");
    property p_hi; regRead |=> regRdata[31:8] == '0; endproperty
    a_hi: assert property (p_hi) else $error("upper read bits set");
endmodule
bind output_port_bit_set_reset outport_props outport_props_inst (.clk(clk), .nrst(nrst),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .auxSource(auxSource), .outPins(outPins));
`default_nettype wire

// *** tb/host_model.sv ***
/* host side of the register port; assumes bench calls tasks right after a rising edge */
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk,
    output logic [7:0] regAddr,
    output logic [31:0] regWdata,
    output logic regWrite,
    output logic regRead,
    input wire logic [31:0] regRdata
);
    initial {regAddr, regWdata, regWrite, regRead} = '0;
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        regRead <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        regAddr <= a;
        regRead <= 1'b1;
        regWrite <= 1'b0;
        @(posedge clk);
        // released bus shows garbage, not the last value
        regRead <= 1'b0;
        regAddr <= ~regAddr;
        regWdata <= ~regWdata;
        // read word stands only until the next edge, so take it mid-cycle
        @(negedge clk);
        d = regRdata;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// *** tb/output_port_bit_set_reset_bench.sv ***
/* bench with integer model of latch and config; assumes host_model drives the bus */
`timescale 1ns/1ps
`default_nettype none
module output_port_bit_set_reset_bench;
    logic clk, nrst, regWrite, regRead;
    logic [7:0] regAddr, auxSource, outPins, a;
    logic [31:0] regWdata, regRdata, rd;
    int errors, n_compared, seed, rg[8];
    output_port_bit_set_reset output_port_bit_set_reset_inst (.clk(clk), .nrst(nrst),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .auxSource(auxSource), .outPins(outPins));
    host_model host_model_inst (.clk(clk), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    function automatic logic [7:0] pins();
        logic [7:0] s;
        s = {rg[2][7:2], rg[4][7] | rg[6][5], rg[3][7] | rg[5][5]};
        return (~rg[7][7:0] & ~s) | (~auxSource & s);
    endfunction
    task automatic w(input logic [7:0] ad, input logic [31:0] d);
        int idx;
        idx = ad[7:2];
        host_model_inst.wr(ad, d);
        if (idx == 0) rg[7] |= d[7:0];
        else if (idx == 1) rg[7] &= ~d[7:0];
        else if (idx < 7) rg[idx] = d[7:0];
    endtask
    task automatic r(input logic [7:0] ad);
        host_model_inst.rd(ad, rd);
        check(rd, ad[7:2] inside {[2:7]} ? 32'(rg[ad[7:2]]) : '0);
    endtask
    initial begin
        #20us;
        errors++;
        summarize();
    end
    initial begin
        {nrst, auxSource} = '0;
        seed = 28;
        repeat (6) @(posedge clk);
        check(outPins, 8'hFF);
        nrst <= 1'b1;
        @(posedge clk);
        r(8'h1C);
        r(8'h00);
        r(8'h04);
        for (int i = 0; i < 45; i++) begin
            a = 8'((i % 9) * 4);
            auxSource <= 8'($random(seed));
            w(a, $random(seed));
            r(a < 8'h08 ? 8'h1C : a);
            check(outPins, pins());
        end
        $display("set, clear and config test done");
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        rg = '{default: 0};
        @(posedge clk);
        r(8'h1C);
        check(outPins, 8'hFF);
        $display("second reset test done");
        summarize();
    end
endmodule
`default_nettype wire
